// ---- inc/host_bus_misc_regs.svh ----
// Offsets, fields, reset values and timing counts of the misc registers
`ifndef HOST_BUS_MISC_REGS_SVH
`define HOST_BUS_MISC_REGS_SVH

`define OFF_MISC_CONTROL_ONE    8'h90
`define OFF_IDLE_DECODE_A       8'h92
`define OFF_IDLE_DECODE_B       8'h93
`define OFF_MISC_CONTROL_TWO    8'h96
`define OFF_INTR_REDIRECT       8'h97

`define RST_MISC_CONTROL_ONE    8'h08
`define RST_IDLE_DECODE_A       8'h00
`define RST_IDLE_DECODE_B       8'h00
`define RST_MISC_CONTROL_TWO    8'h00
`define RST_INTR_REDIRECT       8'h00

`define BIT_MISC_ONE_FIXED      3
`define MSB_READ_ACCEL          1
`define LSB_READ_ACCEL          0
`define RD_SHORTEN_BASE         3'h2

`define BIT_FAST_TARGET_READY           3
`define BIT_FIXED_ZERO_TWO      2
`define BIT_POWER_DYNAMIC       1
`define BIT_POWER_POLICY        0
`define BIT_REDIRECT_LOWEST     0

`define IDLE_BASE_MSB           15
`define IDLE_BASE_LSB           5
`define BE_IDLE_TWO             4
`define BE_IDLE_THREE           5
`define BE_IDLE_FOUR            6
`define BE_IDLE_FIVE            7
`define BE_IDLE_SIX             0

`define TARGET_READY_FAST_CLKS          1
`define TARGET_READY_NORMAL_CLKS        3

`endif

// ---- inc/host_bus_misc_pkg.sv ----
// Types shared by the host bus misc control block
`default_nettype none

package host_bus_misc_pkg;

    typedef enum logic [0:0] {
        TR_IDLE,
        TR_WAIT
    } target_ready_state_t;

    typedef logic [7:0] reg_byte_t;

endpackage

`default_nettype wire

// ---- rtl/idle_level_decoder.sv ----
// Decodes idle-level command reads against the power management I/O base
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_misc_regs.svh"

module idle_level_decoder (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] power_mgmt_io_base,
    input  wire logic        io_read_valid,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_byte_en,
    output var  logic        idle_level_two,
    output var  logic        idle_level_three,
    output var  logic        idle_level_four,
    output var  logic        idle_level_five,
    output var  logic        idle_level_six
);
    logic       hit;
    logic [4:0] next_levels;
    logic [4:0] levels;

    always_comb begin
        hit = io_read_valid &&
              (io_addr[`IDLE_BASE_MSB:`IDLE_BASE_LSB] ==
               power_mgmt_io_base[`IDLE_BASE_MSB:`IDLE_BASE_LSB]);
        next_levels = 5'h00;
        if (hit) begin
            next_levels = {io_byte_en[`BE_IDLE_SIX],
                           io_byte_en[`BE_IDLE_FIVE],
                           io_byte_en[`BE_IDLE_FOUR],
                           io_byte_en[`BE_IDLE_THREE],
                           io_byte_en[`BE_IDLE_TWO]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            levels <= 5'h00;
        end else begin
            levels <= next_levels;
        end
    end

    assign idle_level_two   = levels[0];
    assign idle_level_three = levels[1];
    assign idle_level_four  = levels[2];
    assign idle_level_five  = levels[3];
    assign idle_level_six   = levels[4];
endmodule

`default_nettype wire

// ---- rtl/power_request_ctrl.sv ----
// Drives the host data bus power request from the data phases in flight
`timescale 1ns/1ps
`default_nettype none

module power_request_ctrl (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic dynamic_en,
    input  wire logic policy,
    input  wire logic down_read_phase,
    input  wire logic apic_write_phase,
    input  wire logic down_write_phase,
    input  wire logic snoop_wb_phase,
    output var  logic host_data_power_request_n
);
    logic active;
    logic next_request_n;

    always_comb begin
        if (!dynamic_en) begin
            active = 1'b1;
        end else begin
            active = down_read_phase || apic_write_phase;
            if (!policy) begin
                active = active || down_write_phase ||
                         snoop_wb_phase;
            end
        end
        // Pin is active low: low tells the CPU to power its data pads
        next_request_n = ~active;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_data_power_request_n <= 1'b0;
        end else begin
            host_data_power_request_n <= next_request_n;
        end
    end
endmodule

`default_nettype wire

// ---- rtl/host_bus_misc_control.sv ----
// Host bus miscellaneous control registers and the logic they steer
`timescale 1ns/1ps
`default_nettype none
`include "host_bus_misc_regs.svh"

module host_bus_misc_control
    import host_bus_misc_pkg::*;
#(
    parameter int FAST_TARGET_READY_CLKS   = `TARGET_READY_FAST_CLKS,
    parameter int NORMAL_TARGET_READY_CLKS = `TARGET_READY_NORMAL_CLKS
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [7:0]  reg_rdata,
    input  wire logic        read_timing_sel_a,
    input  wire logic        read_timing_sel_b,
    output var  logic [2:0]  read_cycle_shorten,
    input  wire logic        fast_target_ready_companion_en,
    input  wire logic        cpu_write_req,
    output var  logic        target_ready,
    input  wire logic        io_read_valid,
    input  wire logic [15:0] io_addr,
    input  wire logic [7:0]  io_byte_en,
    output var  logic        idle_level_two,
    output var  logic        idle_level_three,
    output var  logic        idle_level_four,
    output var  logic        idle_level_five,
    output var  logic        idle_level_six,
    input  wire logic        down_read_phase,
    input  wire logic        apic_write_phase,
    input  wire logic        down_write_phase,
    input  wire logic        snoop_wb_phase,
    output var  logic        host_data_power_request_n,
    input  wire logic        msi_valid,
    input  wire logic        msi_lowest_prio,
    input  wire logic [7:0]  msi_dest_id,
    output var  logic        msi_out_valid,
    output var  logic [7:0]  msi_out_dest_id
);
    localparam logic [1:0] FAST_LOAD   = 2'(FAST_TARGET_READY_CLKS - 1);
    localparam logic [1:0] NORMAL_LOAD = 2'(NORMAL_TARGET_READY_CLKS - 1);

    // Register file
    reg_byte_t misc_control_one;
    reg_byte_t idle_level_decode_a;
    reg_byte_t idle_level_decode_b;
    reg_byte_t misc_control_two;
    reg_byte_t interrupt_redirect_control;
    reg_byte_t next_misc_control_one;
    reg_byte_t next_idle_level_decode_a;
    reg_byte_t next_idle_level_decode_b;
    reg_byte_t next_misc_control_two;
    reg_byte_t next_interrupt_redirect_control;
    reg_byte_t next_reg_rdata;

    always_comb begin
        next_misc_control_one           = misc_control_one;
        next_idle_level_decode_a        = idle_level_decode_a;
        next_idle_level_decode_b        = idle_level_decode_b;
        next_misc_control_two           = misc_control_two;
        next_interrupt_redirect_control = interrupt_redirect_control;
        if (reg_wr) begin
            case (reg_addr)
                `OFF_MISC_CONTROL_ONE: begin
                    next_misc_control_one = reg_wdata;
                end
                `OFF_IDLE_DECODE_A: begin
                    next_idle_level_decode_a = reg_wdata;
                end
                `OFF_IDLE_DECODE_B: begin
                    next_idle_level_decode_b = reg_wdata;
                end
                `OFF_MISC_CONTROL_TWO: begin
                    next_misc_control_two = reg_wdata;
                end
                `OFF_INTR_REDIRECT: begin
                    next_interrupt_redirect_control = reg_wdata;
                end
                default: begin
                end
            endcase
        end
        // Read-only bits are pinned so a stray write cannot move them
        next_misc_control_one[`BIT_MISC_ONE_FIXED] = 1'b1;
        next_misc_control_two[`BIT_FIXED_ZERO_TWO] = 1'b0;

        next_reg_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `OFF_MISC_CONTROL_ONE: next_reg_rdata = misc_control_one;
                `OFF_IDLE_DECODE_A:    next_reg_rdata = idle_level_decode_a;
                `OFF_IDLE_DECODE_B:    next_reg_rdata = idle_level_decode_b;
                `OFF_MISC_CONTROL_TWO: next_reg_rdata = misc_control_two;
                `OFF_INTR_REDIRECT: begin
                    next_reg_rdata = interrupt_redirect_control;
                end
                default:               next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            misc_control_one           <= `RST_MISC_CONTROL_ONE;
            idle_level_decode_a        <= `RST_IDLE_DECODE_A;
            idle_level_decode_b        <= `RST_IDLE_DECODE_B;
            misc_control_two           <= `RST_MISC_CONTROL_TWO;
            interrupt_redirect_control <= `RST_INTR_REDIRECT;
            reg_rdata                  <= 8'h00;
        end else begin
            misc_control_one           <= next_misc_control_one;
            idle_level_decode_a        <= next_idle_level_decode_a;
            idle_level_decode_b        <= next_idle_level_decode_b;
            misc_control_two           <= next_misc_control_two;
            interrupt_redirect_control <= next_interrupt_redirect_control;
            reg_rdata                  <= next_reg_rdata;
        end
    end

    // DRAM read acceleration
    logic [1:0] accel_code;
    logic [2:0] next_read_cycle_shorten;

    always_comb begin
        accel_code = misc_control_one[`MSB_READ_ACCEL:`LSB_READ_ACCEL];
        next_read_cycle_shorten = 3'h0;
        // Timing select A gates the whole saving; B trims one clock more
        if (read_timing_sel_a) begin
            next_read_cycle_shorten = {1'b0, accel_code} +
                                      `RD_SHORTEN_BASE +
                                      {2'b00, read_timing_sel_b};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            read_cycle_shorten <= 3'h0;
        end else begin
            read_cycle_shorten <= next_read_cycle_shorten;
        end
    end

    // Target-ready pacing of CPU downstream writes
    target_ready_state_t tr_state;
    target_ready_state_t next_tr_state;
    logic [1:0]  tr_count;
    logic [1:0]  next_tr_count;
    logic        fast_target_ready;
    logic        next_target_ready;

    always_comb begin
        fast_target_ready = misc_control_two[`BIT_FAST_TARGET_READY] &&
                    fast_target_ready_companion_en;
        next_tr_state     = tr_state;
        next_tr_count     = tr_count;
        next_target_ready = 1'b0;
        case (tr_state)
            TR_IDLE: begin
                if (cpu_write_req) begin
                    next_tr_state = TR_WAIT;
                    next_tr_count = fast_target_ready ? FAST_LOAD
                                              : NORMAL_LOAD;
                end
            end
            TR_WAIT: begin
                // Requests arriving here are dropped; the CPU keeps one
                // downstream write outstanding until target-ready
                if (tr_count == 2'h0) begin
                    next_tr_state     = TR_IDLE;
                    next_target_ready = 1'b1;
                end else begin
                    next_tr_count = tr_count - 2'h1;
                end
            end
            default: begin
                next_tr_state = TR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tr_state     <= TR_IDLE;
            tr_count     <= 2'h0;
            target_ready <= 1'b0;
        end else begin
            tr_state     <= next_tr_state;
            tr_count     <= next_tr_count;
            target_ready <= next_target_ready;
        end
    end

    // Lowest-priority MSI routing
    logic       next_msi_out_valid;
    logic [7:0] next_msi_out_dest_id;

    always_comb begin
        next_msi_out_valid   = msi_valid;
        next_msi_out_dest_id = msi_dest_id;
        if (msi_valid && msi_lowest_prio &&
            interrupt_redirect_control[`BIT_REDIRECT_LOWEST]) begin
            next_msi_out_dest_id = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            msi_out_valid   <= 1'b0;
            msi_out_dest_id <= 8'h00;
        end else begin
            msi_out_valid   <= next_msi_out_valid;
            msi_out_dest_id <= next_msi_out_dest_id;
        end
    end

    idle_level_decoder u_idle_level_decoder (
        .clk                (clk),
        .rst_n              (rst_n),
        .power_mgmt_io_base ({idle_level_decode_b, idle_level_decode_a}),
        .io_read_valid      (io_read_valid),
        .io_addr            (io_addr),
        .io_byte_en         (io_byte_en),
        .idle_level_two     (idle_level_two),
        .idle_level_three   (idle_level_three),
        .idle_level_four    (idle_level_four),
        .idle_level_five    (idle_level_five),
        .idle_level_six     (idle_level_six)
    );

    power_request_ctrl u_power_request_ctrl (
        .clk                       (clk),
        .rst_n                     (rst_n),
        .dynamic_en                (misc_control_two[`BIT_POWER_DYNAMIC]),
        .policy                    (misc_control_two[`BIT_POWER_POLICY]),
        .down_read_phase           (down_read_phase),
        .apic_write_phase          (apic_write_phase),
        .down_write_phase          (down_write_phase),
        .snoop_wb_phase            (snoop_wb_phase),
        .host_data_power_request_n (host_data_power_request_n)
    );
endmodule

`default_nettype wire

// ---- bench/host_bus_misc_control_sva.sv ----
// Port-level assertions for the host bus misc control block
`timescale 1ns/1ps
`default_nettype none

module host_bus_misc_checker #(
    parameter int FAST_TARGET_READY_CLKS   = 1,
    parameter int NORMAL_TARGET_READY_CLKS = 3
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       read_timing_sel_a,
    input wire logic [2:0] read_cycle_shorten,
    input wire logic       cpu_write_req,
    input wire logic       target_ready,
    input wire logic       io_read_valid,
    input wire logic [7:0] io_byte_en,
    input wire logic       idle_level_two,
    input wire logic       idle_level_six,
    input wire logic       down_read_phase,
    input wire logic       apic_write_phase,
    input wire logic       host_data_power_request_n,
    input wire logic       msi_valid,
    input wire logic       msi_lowest_prio,
    input wire logic [7:0] msi_dest_id,
    input wire logic       msi_out_valid,
    input wire logic [7:0] msi_out_dest_id
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_rdata_quiet;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_shorten_range;
        $past(read_timing_sel_a) && $past(rst_n)
            |-> read_cycle_shorten inside {[3'h2:3'h6]};
    endproperty
    property p_shorten_gate;
        !$past(read_timing_sel_a) |-> read_cycle_shorten == 3'h0;
    endproperty
    property p_idle_two;
        idle_level_two |-> $past(io_read_valid && io_byte_en[4]);
    endproperty
    property p_idle_six;
        idle_level_six |-> $past(io_read_valid && io_byte_en[0]);
    endproperty
    property p_target_ready_pulse;
        target_ready |=> !target_ready;
    endproperty
    property p_target_ready_cause;
        target_ready |-> $past(cpu_write_req, FAST_TARGET_READY_CLKS + 1)
            || $past(cpu_write_req, NORMAL_TARGET_READY_CLKS + 1);
    endproperty
    property p_power_read;
        $past(down_read_phase || apic_write_phase)
            |-> !host_data_power_request_n;
    endproperty
    property p_msi_valid;
        $past(rst_n) |-> msi_out_valid == $past(msi_valid);
    endproperty
    property p_msi_dest;
        msi_out_valid && !$past(msi_lowest_prio)
            |-> msi_out_dest_id == $past(msi_dest_id);
    endproperty

    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("read data outside its cycle");
    a_shorten_range: assert property (p_shorten_range)
        else $error("read shortening out of range");
    a_shorten_gate: assert property (p_shorten_gate)
        else $error("read shortening without timing select");
    a_idle_two: assert property (p_idle_two)
        else $error("level two without enable bit four");
    a_idle_six: assert property (p_idle_six)
        else $error("level six without enable bit zero");
    a_target_ready_pulse: assert property (p_target_ready_pulse)
        else $error("target ready longer than one cycle");
    a_target_ready_cause: assert property (p_target_ready_cause)
        else $error("target ready at wrong distance");
    a_power_read: assert property (p_power_read)
        else $error("power request missing on read phase");
    a_msi_valid: assert property (p_msi_valid)
        else $error("msi valid not passed on");
    a_msi_dest: assert property (p_msi_dest)
        else $error("msi destination altered");

    c_target_ready: cover property (target_ready);
    c_idle: cover property (idle_level_six);
    c_redirect: cover property (msi_out_valid && msi_out_dest_id == 8'h00
        && $past(msi_dest_id) != 8'h00);
endmodule

bind host_bus_misc_control host_bus_misc_checker #(
    .FAST_TARGET_READY_CLKS   (FAST_TARGET_READY_CLKS),
    .NORMAL_TARGET_READY_CLKS (NORMAL_TARGET_READY_CLKS)
) host_bus_misc_checker_i (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .read_timing_sel_a         (read_timing_sel_a),
    .read_cycle_shorten        (read_cycle_shorten),
    .cpu_write_req             (cpu_write_req),
    .target_ready              (target_ready),
    .io_read_valid             (io_read_valid),
    .io_byte_en                (io_byte_en),
    .idle_level_two            (idle_level_two),
    .idle_level_six            (idle_level_six),
    .down_read_phase           (down_read_phase),
    .apic_write_phase          (apic_write_phase),
    .host_data_power_request_n (host_data_power_request_n),
    .msi_valid                 (msi_valid),
    .msi_lowest_prio           (msi_lowest_prio),
    .msi_dest_id               (msi_dest_id),
    .msi_out_valid             (msi_out_valid),
    .msi_out_dest_id           (msi_out_dest_id)
);
`default_nettype wire

// ---- bench/host_cpu_model.sv ----
// Host processor model: write requests, data phases, idle reads, MSI
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model (
    input  wire logic        clk,
    output var  logic        cpu_write_req,
    output var  logic [3:0]  phase,
    output var  logic        io_read_valid,
    output var  logic [15:0] io_addr,
    output var  logic [7:0]  io_byte_en,
    output var  logic        msi_valid,
    output var  logic        msi_lowest_prio,
    output var  logic [7:0]  msi_dest_id
);
    initial begin
        cpu_write_req = 1'b0;
        phase = 4'h0;
        io_read_valid = 1'b0;
        io_addr = 16'h0000;
        io_byte_en = 8'h00;
        msi_valid = 1'b0;
        msi_lowest_prio = 1'b0;
        msi_dest_id = 8'h00;
    end

    // Request held for len cycles; later cycles probe the refusal window
    task automatic write_req(input int len);
        @(posedge clk);
        cpu_write_req <= 1'b1;
        repeat (len) @(posedge clk);
        cpu_write_req <= 1'b0;
    endtask

    // Bit 0 read, 1 APIC write, 2 downstream write, 3 snoop write-back
    task automatic set_phase(input logic [3:0] p);
        @(posedge clk);
        phase <= p;
    endtask

    // Lines drop to the inverse once released, never the last value
    task automatic io_read(input logic [15:0] a, input logic [7:0] be);
        @(posedge clk);
        io_read_valid <= 1'b1;
        io_addr <= a;
        io_byte_en <= be;
        @(posedge clk);
        io_read_valid <= 1'b0;
        io_addr <= ~a;
        io_byte_en <= ~be;
    endtask

    task automatic msi(input logic lp, input logic [7:0] d);
        @(posedge clk);
        msi_valid <= 1'b1;
        msi_lowest_prio <= lp;
        msi_dest_id <= d;
        @(posedge clk);
        msi_valid <= 1'b0;
        msi_lowest_prio <= ~lp;
        msi_dest_id <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- bench/host_bus_misc_control_bench.sv ----
// Self-checking bench for the host bus misc control block
`timescale 1ns/1ps
`default_nettype none

module host_bus_misc_control_bench;
    import host_bus_misc_pkg::*;

    logic        clk;
    logic        rst_n = 1'b0;
    reg_byte_t   reg_addr = 8'h00;
    reg_byte_t   reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    reg_byte_t   reg_rdata;
    logic        sel_a = 1'b0;
    logic        sel_b = 1'b0;
    logic [2:0]  shorten;
    logic        comp_en = 1'b0;
    logic        cpu_write_req;
    logic        target_ready;
    logic        io_read_valid;
    logic [15:0] io_addr;
    logic [7:0]  io_byte_en;
    logic [4:0]  lvl;
    logic [3:0]  phase;
    logic        hdpr_n;
    logic        msi_valid;
    logic        msi_lowest_prio;
    logic [7:0]  msi_dest_id;
    logic        msi_out_valid;
    logic [7:0]  msi_out_dest_id;
    int          failures = 0;
    int          check_count = 0;

    host_cpu_model host_cpu_model_i (
        .clk(clk), .cpu_write_req(cpu_write_req), .phase(phase),
        .io_read_valid(io_read_valid), .io_addr(io_addr),
        .io_byte_en(io_byte_en), .msi_valid(msi_valid),
        .msi_lowest_prio(msi_lowest_prio), .msi_dest_id(msi_dest_id));

    host_bus_misc_control #(.FAST_TARGET_READY_CLKS(1), .NORMAL_TARGET_READY_CLKS(3))
    host_bus_misc_control_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .read_timing_sel_a(sel_a),
        .read_timing_sel_b(sel_b), .read_cycle_shorten(shorten),
        .fast_target_ready_companion_en(comp_en), .cpu_write_req(cpu_write_req),
        .target_ready(target_ready), .io_read_valid(io_read_valid),
        .io_addr(io_addr), .io_byte_en(io_byte_en),
        .idle_level_two(lvl[4]), .idle_level_three(lvl[3]),
        .idle_level_four(lvl[2]), .idle_level_five(lvl[1]),
        .idle_level_six(lvl[0]), .down_read_phase(phase[0]),
        .apic_write_phase(phase[1]), .down_write_phase(phase[2]),
        .snoop_wb_phase(phase[3]), .host_data_power_request_n(hdpr_n),
        .msi_valid(msi_valid), .msi_lowest_prio(msi_lowest_prio),
        .msi_dest_id(msi_dest_id), .msi_out_valid(msi_out_valid),
        .msi_out_dest_id(msi_out_dest_id));

    task automatic chk(input reg_byte_t got, input reg_byte_t exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input reg_byte_t a, input reg_byte_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input reg_byte_t a, input reg_byte_t exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // Last entry is an unmapped place between the two control bytes
    task automatic t_regs();
        reg_byte_t a[6] = '{8'h90, 8'h92, 8'h93, 8'h96, 8'h97, 8'h91};
        reg_byte_t lo[6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        reg_byte_t hi[6] = '{8'hff, 8'hff, 8'hff, 8'hfb, 8'hff, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], lo[i]);
            wr(a[i], 8'hff);
            rd(a[i], hi[i]);
            wr(a[i], 8'h00);
            rd(a[i], lo[i]);
        end
    endtask

    task automatic t_accel();
        int e;
        for (int c = 0; c < 4; c++) begin
            wr(8'h90, reg_byte_t'(c));
            for (int s = 0; s < 4; s++) begin
                @(posedge clk);
                sel_a <= s[1];
                sel_b <= s[0];
                e = s[1] ? c + 2 + s[0] : 0;
                repeat (2) @(posedge clk);
                #1 chk({5'h0, shorten}, reg_byte_t'(e));
            end
        end
    endtask

    task automatic t_target_ready();
        int n;
        for (int m = 0; m < 4; m++) begin
            wr(8'h96, {4'h0, m[1], 3'h0});
            @(posedge clk);
            comp_en <= m[0];
            n = (m == 3) ? 1 : 3;
            host_cpu_model_i.write_req(n);
            #1;
            while (target_ready !== 1'b1 && n < 9) begin
                @(posedge clk);
                #1 n++;
            end
            chk(reg_byte_t'(n), (m == 3) ? 8'h02 : 8'h04);
        end
        wr(8'h96, 8'h00);
    endtask

    task automatic t_power();
        logic [3:0] ph[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
        logic       quiet;
        for (int m = 0; m < 4; m++) begin
            wr(8'h96, {6'h0, m[1:0]});
            for (int i = 0; i < 5; i++) begin
                // Pin is active low: high only while dynamic and unneeded
                quiet = m[1] && (i == 0 || i > 2 && m[0]);
                host_cpu_model_i.set_phase(ph[i]);
                @(posedge clk);
                #1;
                chk({7'h0, hdpr_n}, {7'h0, quiet});
            end
        end
        host_cpu_model_i.set_phase(4'h0);
    endtask

    // Base 0x1234 keeps 0x1220..0x123f; 0x1240 and 0x1210 fall outside
    task automatic t_idle();
        logic [15:0] a;
        logic [7:0]  be;
        logic [7:0]  e;
        wr(8'h92, 8'h34);
        wr(8'h93, 8'h12);
        for (int i = 0; i < 11; i++) begin
            a = (i == 9) ? 16'h1240 : (i == 10) ? 16'h1210 : 16'h1220 + 16'(i);
            be = (i < 8) ? 8'h01 << i : 8'hf1;
            host_cpu_model_i.io_read(a, be);
            e = (i > 8) ? 8'h00 : {3'h0, be[4], be[5], be[6], be[7], be[0]};
            #1 chk({3'h0, lvl}, e);
        end
    endtask

    task automatic t_msi();
        for (int m = 0; m < 4; m++) begin
            wr(8'h97, {7'h0, m[1]});
            host_cpu_model_i.msi(m[0], 8'h5c);
            #1 chk(msi_out_dest_id, (m == 3) ? 8'h00 : 8'h5c);
            chk({7'h0, msi_out_valid}, 8'h01);
        end
    endtask

    task automatic conclude();
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_accel();
        t_target_ready();
        t_power();
        t_idle();
        t_msi();
        conclude();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
